/* rtl/div_cfg.svh */
`ifndef DIV_CFG_SVH
`define DIV_CFG_SVH

// ----------------------------------------------------------------
// datapath widths
// ----------------------------------------------------------------
`define WORD_W        16
`define COUNT_W       5

// ----------------------------------------------------------------
// field positions of the divide opcode, and the sign bit of a data word
// ----------------------------------------------------------------
`define COUNT_LSB     0
`define COUNT_MSB     4
`define SIGN_BIT      15

// ----------------------------------------------------------------
// reset values and increment constants
// ----------------------------------------------------------------
`define WORD_RST      16'h0000
`define COUNT_RST     5'h00
`define COUNT_STEP    5'h01
`define WORD_ONE      16'h0001

`endif

/* rtl/div_pkg.sv */
package div_pkg;

  typedef enum logic [2:0] {
    FETCH_STATE      = 3'b001,
    EXECUTE_STATE    = 3'b101,
    INTERRUPT_STATE  = 3'b111,
    STEAL_STATE      = 3'b000,
    SHIFT_LOOP_STATE = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    PH_1 = 2'b00,
    PH_2 = 2'b01,
    PH_3 = 2'b10,
    PH_4 = 2'b11
  } seq_phase_t;

  typedef struct packed {
    seq_state_t  seq;
    seq_phase_t  phase;
    seq_state_t  ret_seq;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] q;
    logic [15:0] r;
    logic [15:0] w;
    logic [15:0] pc;
    logic [15:0] l_count;
    logic [4:0]  count;
    logic [4:0]  sc;
    logic        skip;
    logic        no_irq_op;
    logic        fast;
    logic        link;
    logic        flag;
    logic        eos;
    logic        done;
    logic        irq_ack;
    logic        steal_meta;
    logic        steal_sync;
    logic        irq_meta;
    logic        irq_sync;
  } seq_regs_t;

endpackage : div_pkg

/* rtl/alu_if.sv */
`timescale 1ns/1ns
interface alu_if;
  logic [15:0] augend;
  logic [15:0] addend;
  logic        carry_in;
  logic [15:0] sum;
  logic        carry_out;

  modport master (output augend, output addend, output carry_in,
                  input sum, input carry_out);
  modport alu    (input augend, input addend, input carry_in,
                  output sum, output carry_out);
endinterface : alu_if

/* rtl/shift_add_alu.sv */
`timescale 1ns/1ns
`include "div_cfg.svh"
module shift_add_alu
  import div_pkg::*;
(
  alu_if.alu port_alu
);
  logic [16:0] full;

  // doubling is augend added to itself, subtraction is augend plus inverted addend plus one
  assign full               = {1'b0, port_alu.augend} + {1'b0, port_alu.addend}
                              + {16'h0000, port_alu.carry_in};
  assign port_alu.sum       = full[`WORD_W-1:0];
  assign port_alu.carry_out = full[`WORD_W];
endmodule : shift_add_alu

/* rtl/shift_subtract_divide_sequencer.sv */
`timescale 1ns/1ns
`include "div_cfg.svh"
module shift_subtract_divide_sequencer
  import div_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic [15:0] instr,
  input  wire logic [15:0] divisor_in,
  input  wire logic [15:0] dividend_hi_in,
  input  wire logic [15:0] dividend_lo_in,
  input  wire logic [15:0] pc_in,
  input  wire logic        skip_adjust,
  input  wire logic        jump_or_call,
  input  wire logic        rom_exec,
  input  wire logic        mem_ref,
  input  wire logic        steal_request,
  input  wire logic        interrupt_request,
  output logic      [15:0] remainder,
  output logic      [15:0] quotient,
  output logic      [15:0] pc,
  output logic      [15:0] l_counter,
  output logic      [4:0]  shift_counter,
  output logic             phase_flag,
  output logic             link,
  output logic             end_of_shift,
  output logic             busy,
  output logic             done,
  output logic             interrupt_ack,
  output logic             steal_grant,
  output logic             turn,
  output logic      [2:0]  seq_state,
  output logic      [1:0]  seq_phase
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // one packed struct holds every register; next_cur is its combinational image
  seq_regs_t cur;
  seq_regs_t next_cur;

  alu_if alu_bus ();

  shift_add_alu u_alu (
    .port_alu (alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // alu operand steering
  // ----------------------------------------------------------------
  logic in_loop;
  logic sub_step;
  logic w_step;

  assign in_loop  = (cur.seq == SHIFT_LOOP_STATE);
  assign sub_step = in_loop && (cur.phase == PH_1);
  assign w_step   = in_loop && (cur.phase == PH_2);

  // one adder serves all three loop steps; the select is decoded from state only
  // doubling feeds one register to both inputs; subtraction inverts R
  assign alu_bus.augend   = w_step ? cur.w : cur.q;
  assign alu_bus.addend   = sub_step ? ~cur.r : (w_step ? cur.w : cur.q);
  assign alu_bus.carry_in = sub_step ? 1'b1 : cur.link;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // counter wraps at 32, so a zero count field runs 32 passes
  logic [4:0] sc_inc;
  assign sc_inc = cur.sc + `COUNT_STEP;

  always_comb begin
    next_cur            = cur;
    next_cur.done       = 1'b0;
    next_cur.irq_ack    = 1'b0;

    // pins from outside the clock domain pass two flops; only the second
    // stage is ever read, so a metastable first stage cannot fan out
    next_cur.steal_meta = steal_request;
    next_cur.steal_sync = cur.steal_meta;
    next_cur.irq_meta   = interrupt_request;
    next_cur.irq_sync   = cur.irq_meta;

    unique case (cur.seq)
      FETCH_STATE: begin
        unique case (cur.phase)
          PH_1: begin
            // operands and mode bits are captured once, so inputs may move while busy
            if (start) begin
              next_cur.a         = divisor_in;
              next_cur.b         = dividend_hi_in;
              next_cur.c         = dividend_lo_in;
              next_cur.pc        = pc_in;
              next_cur.count     = instr[`COUNT_MSB:`COUNT_LSB];
              next_cur.skip      = skip_adjust;
              next_cur.no_irq_op = jump_or_call;
              next_cur.fast      = rom_exec && !mem_ref;
              next_cur.phase     = PH_2;
            end
          end
          PH_2: begin
            next_cur.q     = cur.c;
            next_cur.r     = cur.a;
            next_cur.pc    = cur.pc + `WORD_ONE + {15'h0000, cur.skip};
            next_cur.sc    = `COUNT_RST;
            // a left-over end of shift must not cut the next loop short
            next_cur.eos   = 1'b0;
            next_cur.flag  = 1'b1;
            next_cur.seq   = EXECUTE_STATE;
            next_cur.phase = PH_3;
          end
          default: begin
            next_cur.phase = PH_1;
          end
        endcase
      end

      EXECUTE_STATE: begin
        unique case (cur.phase)
          PH_3: begin
            if (cur.flag) begin
              next_cur.w     = cur.q;
              next_cur.link  = 1'b0;
              next_cur.seq   = SHIFT_LOOP_STATE;
              next_cur.phase = PH_2;
            end else if (cur.fast) begin
              // overlapped finish: the idle phase absorbs the L update
              next_cur.l_count = cur.pc;
              next_cur.done    = 1'b1;
              next_cur.seq     = FETCH_STATE;
              next_cur.phase   = PH_1;
              if (cur.irq_sync && !cur.no_irq_op) begin
                next_cur.seq     = INTERRUPT_STATE;
                next_cur.irq_ack = 1'b1;
              end
            end else begin
              // flag clear and not overlapped: idle phase, nothing moves
              next_cur.phase = PH_4;
            end
          end
          PH_4: begin
            next_cur.l_count = cur.pc;
            next_cur.done    = 1'b1;
            next_cur.seq     = FETCH_STATE;
            next_cur.phase   = PH_1;
            // jump and call never take the interrupt, so their link survives
            if (cur.irq_sync && !cur.no_irq_op) begin
              next_cur.seq     = INTERRUPT_STATE;
              next_cur.irq_ack = 1'b1;
            end
          end
          default: begin
            next_cur.phase = PH_3;
          end
        endcase
      end

      SHIFT_LOOP_STATE: begin
        unique case (cur.phase)
          PH_1: begin
            next_cur.link = alu_bus.carry_out;
            // a set sign bit means the divisor did not fit: B keeps its value
            if (!alu_bus.sum[`SIGN_BIT]) begin
              next_cur.b = alu_bus.sum;
            end
            next_cur.phase = PH_2;
          end
          PH_2: begin
            // the last pass still shifts the final quotient bit in before leaving
            next_cur.q    = cur.b;
            next_cur.c    = alu_bus.sum;
            next_cur.w    = alu_bus.sum;
            next_cur.link = alu_bus.carry_out;
            next_cur.flag = 1'b0;
            if (cur.eos) begin
              next_cur.seq   = EXECUTE_STATE;
              next_cur.phase = PH_3;
            end else begin
              next_cur.phase = PH_3;
            end
          end
          PH_3: begin
            next_cur.b     = alu_bus.sum;
            next_cur.link  = alu_bus.carry_out;
            next_cur.sc    = sc_inc;
            // known one pass ahead, so the following phase 2 can exit
            next_cur.eos   = (sc_inc == cur.count);
            next_cur.phase = PH_4;
          end
          PH_4: begin
            next_cur.q     = cur.b;
            next_cur.phase = PH_1;
          end
        endcase
      end

      INTERRUPT_STATE: begin
        // minimal service stub: four phases, L takes the program counter;
        // the vector fetch itself lives outside this block
        unique case (cur.phase)
          PH_4: begin
            next_cur.l_count = cur.pc;
            next_cur.seq     = FETCH_STATE;
            next_cur.phase   = PH_1;
          end
          default: begin
            next_cur.phase = seq_phase_t'(cur.phase + 2'b01);
          end
        endcase
      end

      STEAL_STATE: begin
        unique case (cur.phase)
          PH_3: begin
            // grant stands for the four stolen phases; the requester drops on it
            // the interrupted state picks up again at its own phase 4
            next_cur.seq   = cur.ret_seq;
            next_cur.phase = PH_4;
          end
          default: begin
            next_cur.phase = seq_phase_t'(cur.phase + 2'b01);
          end
        endcase
      end

      // unused state codes fall back to fetch rather than hang
      default: begin
        next_cur.seq   = FETCH_STATE;
        next_cur.phase = PH_1;
      end
    endcase

    // steal only where phase 3 would step to phase 4 of the same state
    // elsewhere the resume point would skip the phase that state was about to run
    if (cur.phase == PH_3 && cur.seq != STEAL_STATE && cur.steal_sync
        && next_cur.seq == cur.seq && next_cur.phase == PH_4) begin
      next_cur.ret_seq = cur.seq;
      next_cur.seq     = STEAL_STATE;
      next_cur.phase   = PH_4;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all-zero is the steal code, so reset names the fetch codes explicitly
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur            <= '0;
      cur.seq        <= FETCH_STATE;
      cur.phase      <= PH_1;
      cur.ret_seq    <= FETCH_STATE;
      cur.sc         <= `COUNT_RST;
      cur.count      <= `COUNT_RST;
      cur.pc         <= `WORD_RST;
      cur.l_count    <= `WORD_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // B and C already hold the result from loop exit on, before done pulses
  // busy and steal_grant decode state directly so requesters see them at once;
  // every data output is a flop
  assign remainder     = cur.b;
  assign quotient      = cur.c;
  assign pc            = cur.pc;
  assign l_counter     = cur.l_count;
  assign shift_counter = cur.sc;
  assign phase_flag    = cur.flag;
  assign link          = cur.link;
  assign end_of_shift  = cur.eos;
  assign done          = cur.done;
  assign interrupt_ack = cur.irq_ack;
  assign steal_grant   = (cur.seq == STEAL_STATE);
  assign busy          = !((cur.seq == FETCH_STATE) && (cur.phase == PH_1));
  assign turn          = busy && cur.fast;
  assign seq_state     = cur.seq;
  assign seq_phase     = cur.phase;

endmodule : shift_subtract_divide_sequencer

/* bench/divide_checker_assertions.sv */
`timescale 1ns/1ns
module divide_checker
  import div_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        start,
  input wire logic        busy,
  input wire logic [2:0]  seq_state,
  input wire logic [1:0]  seq_phase,
  input wire logic        phase_flag,
  input wire logic        link,
  input wire logic [4:0]  shift_counter,
  input wire logic        end_of_shift,
  input wire logic        steal_grant,
  input wire logic        done,
  input wire logic        interrupt_ack,
  input wire logic [15:0] pc,
  input wire logic [15:0] l_counter,
  input wire logic        turn
);
  // ------
  // state decode
  // ------
  wire f2 = seq_state == FETCH_STATE && seq_phase == PH_2;
  wire e3 = seq_state == EXECUTE_STATE && seq_phase == PH_3;
  wire e4 = seq_state == EXECUTE_STATE && seq_phase == PH_4;
  wire l1 = seq_state == SHIFT_LOOP_STATE && seq_phase == PH_1;
  wire l2 = seq_state == SHIFT_LOOP_STATE && seq_phase == PH_2;
  wire l3 = seq_state == SHIFT_LOOP_STATE && seq_phase == PH_3;
  wire l4 = seq_state == SHIFT_LOOP_STATE && seq_phase == PH_4;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_take_start: assert property (start && !busy |=> f2 && busy)
    else $error("start not taken from idle");
  a_fetch_setup: assert property (f2 |=> e3 && phase_flag && shift_counter == 5'h00)
    else $error("fetch phase 2 setup wrong");
  a_enter_loop: assert property (e3 && phase_flag |=> l2 && !link)
    else $error("loop entry wrong");
  a_loop_clear: assert property (l2 && !end_of_shift |=> l3 && !phase_flag)
    else $error("flag left set in loop");
  a_count_step: assert property (l3 |=> shift_counter == $past(shift_counter) + 5'h01)
    else $error("shift counter not stepped");
  a_loop_return: assert property (l4 |=> l1 ##1 l2)
    else $error("loop order broken");
  a_shift_exit: assert property (l2 && end_of_shift |=> e3 && !phase_flag)
    else $error("loop exit wrong");
  a_exec_finish: assert property (e4 |=> done && l_counter == $past(pc))
    else $error("execute end wrong");
  a_irq_follow: assert property (interrupt_ack |-> done ##1 seq_state == INTERRUPT_STATE)
    else $error("interrupt not at completion");
  a_steal_span: assert property ($rose(steal_grant) |-> seq_phase == PH_4 ##0
    steal_grant [*4] ##1 !steal_grant && seq_phase == PH_4)
    else $error("stolen cycle span wrong");
  a_fast_skip: assert property (e3 && !phase_flag && turn |=> done)
    else $error("overlap did not skip");
endmodule : divide_checker

bind shift_subtract_divide_sequencer divide_checker u_chk (.clk_sys, .srst, .start, .busy,
  .seq_state, .seq_phase, .phase_flag, .link, .shift_counter, .end_of_shift, .steal_grant,
  .done, .interrupt_ack, .pc, .l_counter, .turn);

/* bench/steal_source.sv */
`timescale 1ns/1ns
module steal_source (
  input wire logic clk_sys,
  input wire logic arm,
  input wire logic steal_grant,
  output logic     steal_request
);
  // ------
  // requester
  // ------
  // holds its level until granted, then lets go so one grant is one word
  initial steal_request = 1'b0;
  always @(negedge clk_sys) begin
    if (steal_grant)
      steal_request <= 1'b0;
    else if (arm)
      steal_request <= 1'b1;
  end
endmodule : steal_source

/* bench/shift_subtract_divide_sequencer_bench.sv */
`timescale 1ns/1ns
module shift_subtract_divide_sequencer_bench;
  import div_pkg::*;
  logic        clk_sys = 1'b0, srst = 1'b1, start = 1'b0, skip_adjust = 1'b0, arm = 1'b0;
  logic        jump_or_call = 1'b0, rom_exec = 1'b0, mem_ref = 1'b0, interrupt_request = 1'b0;
  logic [15:0] instr = 16'h0000, divisor_in = 16'h0000, dividend_hi_in = 16'h0000;
  logic [15:0] dividend_lo_in = 16'h0000, pc_in = 16'h0000;
  logic        steal_request, phase_flag, link, end_of_shift, busy, done, interrupt_ack;
  logic        steal_grant, turn;
  logic [15:0] remainder, quotient, pc, l_counter;
  logic [4:0]  shift_counter;
  logic [2:0]  seq_state;
  logic [1:0]  seq_phase;
  int          miscompares = 0, total_checks = 0, seed = 85412;

  always #50 clk_sys = ~clk_sys;

  shift_subtract_divide_sequencer uut (.clk_sys, .srst, .start, .instr, .divisor_in,
    .dividend_hi_in, .dividend_lo_in, .pc_in, .skip_adjust, .jump_or_call, .rom_exec,
    .mem_ref, .steal_request, .interrupt_request, .remainder, .quotient, .pc, .l_counter,
    .shift_counter, .phase_flag, .link, .end_of_shift, .busy, .done, .interrupt_ack,
    .steal_grant, .turn, .seq_state, .seq_phase);
  steal_source partner (.clk_sys, .arm, .steal_grant, .steal_request);

  // ------
  // reference and reporting
  // ------
  // steps the loop register by register; n of zero runs 32 passes
  function automatic logic [31:0] div_ref(logic [15:0] a, b, c, logic [4:0] n);
    logic [15:0] q, w, d;
    logic        lk;
    int          cnt;
    cnt = (n == 5'h00) ? 32 : n;
    w = c;
    lk = 1'b0;
    for (int i = 0; i <= cnt; i++) begin
      q = b;
      {lk, w} = {w, lk};
      if (i == cnt)
        break;
      {lk, b} = {q, lk};
      q = b;
      {lk, d} = {1'b0, q} + {1'b0, ~a} + 17'h00001;
      if (!d[15])
        b = d;
    end
    return {b, w};
  endfunction : div_ref

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  task run(input logic [15:0] a, b, c, input logic [4:0] n, input logic f, j, ir, st);
    logic [31:0] exp;
    logic [15:0] ep;
    logic        pg;
    int          cyc, steals, i;
    @(negedge clk_sys);
    for (i = 0; i < 50 && busy !== 1'b0; i++)
      @(negedge clk_sys);
    exp = div_ref(a, b, c, n);
    divisor_in = a;
    dividend_hi_in = b;
    dividend_lo_in = c;
    instr = {11'($random(seed)), n};
    pc_in = 16'($random(seed));
    skip_adjust = 1'($random(seed));
    rom_exec = f;
    mem_ref = !f;
    jump_or_call = j;
    interrupt_request = ir;
    arm = st;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    cyc = 0;
    steals = 0;
    pg = 1'b0;
    while (done !== 1'b1 && cyc < 400) begin
      @(posedge clk_sys);
      #1;
      cyc++;
      if (steal_grant === 1'b1 && !pg)
        steals++;
      pg = steal_grant;
    end
    if (cyc >= 400 || i >= 50) begin
      miscompares++;
      give_verdict();
    end else begin
      ep = pc_in + 16'h0001 + skip_adjust;
      check(cyc, 4 * ((n == 5'h00) ? 32 : n) + (f ? 4 : 5) + 4 * steals, "latency");
      check(shift_counter, n, "shift count");
      check(quotient, exp[15:0], "quotient");
      check(remainder, exp[31:16], "remainder");
      check(pc, ep, "program counter");
      if (!f)
        check(l_counter, ep, "l counter");
      check(interrupt_ack, ir && !j, "interrupt ack");
    end
  endtask : run

  // ------
  // sequence
  // ------
  initial begin
    logic [15:0] ra, rb, rc;
    logic [4:0]  rn;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    run(16'h0007, 16'h0006, 16'hffff, 5'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    run(16'h7fff, 16'h0000, 16'h8000, 5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
    run(16'h0003, 16'h0001, 16'h0000, 5'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    run(16'h1234, 16'h0100, 16'h5000, 5'h05, 1'b1, 1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 24; k++) begin
      ra = {1'b0, 15'($random(seed))} | 16'h0001;
      rb = 16'($random(seed)) % ra;
      rn = (k < 12) ? 5'h10 : 5'($random(seed));
      rc = 16'($random(seed));
      if (rn != 5'h00 && rn < 5'h10)
        rc = rc & ~(16'hffff >> rn);
      run(ra, rb, rc, rn, 1'($random(seed)), 1'($random(seed)),
          1'($random(seed)), 1'($random(seed)));
      if (k < 12)
        check(32'(quotient) * ra + remainder, {rb, dividend_lo_in}, "rebuild");
    end
    give_verdict();
  end
endmodule : shift_subtract_divide_sequencer_bench
